// >>> dv/smbsp_master_model.sv
// Purpose: behavioural two-wire bus master for the slave bench
// Assumes: open-drain bus with pull-ups formed in the bench
// Notes:   a high flag pulls its line low; a released line reads high; changes land on mclk rise
`timescale 1ns/1ps
module smbsp_master_model #(
  parameter int Q = 20
) (
  // pacing clock
  input  wire logic mclk,
  // bus level seen
  input  wire logic sda,
  // pull-down drives
  output logic      scl_low,
  output logic      sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // one bus phase; longer than the fast-mode filter so every edge passes
  task automatic phase();
    repeat (Q) @(posedge mclk);
  endtask
  task automatic start();
    sda_low <= 1'b0;
    phase();
    scl_low <= 1'b0;
    phase();
    sda_low <= 1'b1;
    phase();
    scl_low <= 1'b1;
    phase();
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    phase();
    scl_low <= 1'b0;
    phase();
    sda_low <= 1'b0;
    phase();
  endtask
  // data set only while scl low
  task automatic bit_io(input logic b, output logic s);
    sda_low <= !b;
    phase();
    scl_low <= 1'b0;
    phase();
    s = sda;
    phase();
    scl_low <= 1'b1;
    phase();
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask
  // byte in, then ack when ack is high, nack when low
  task automatic rbyte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, b[i]);
    end
    bit_io(!ack, s);
  endtask
endmodule // smbsp_master_model

// >>> dv/test_smbus_slave_pointer_interface.sv
// Purpose: self-checking bench for the two-wire slave
// Assumes: short timeout count so the run stays brief
// Notes:   scl phase of 20 clocks keeps every edge longer than the fast-mode glitch filter
`timescale 1ns/1ps
module test_smbus_slave_pointer_interface;
  localparam int         TO   = 2000;
  localparam logic [6:0] ADDR = smbsp_pkg::ADDR_VARIANT_B;
  logic        mclk = 1'b0;
  logic        rst  = 1'b1;
  logic [7:0]  consec_alert_reg = 8'h01;
  logic [7:0]  rd_data = 8'h00;
  logic [7:0]  reg_pointer, wr_data;
  logic        scl_low, sda_low, scl_oe, sda_oe, scl_out, sda_out;
  logic        wr_strobe, rd_strobe, hs_mode, busy;
  logic [7:0]  exp_q[$];
  logic [31:0] rs = 32'h16;
  int          fail_count = 0;
  int          n_checks = 0;
  int          n_rd = 0;
  wire logic   scl = !(scl_low | scl_oe);
  wire logic   sda = !(sda_low | sda_oe);
  always #2.5 mclk = !mclk;
  // register file stand-in: contents follow the pointer
  always @(posedge mclk) rd_data <= reg_pointer ^ 8'h3C;
  smbsp_slave #(.SLAVE_ADDR(ADDR), .TIMEOUT_CYCLES(TO)) i_dut (
    .mclk(mclk), .rst(rst), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .consec_alert_reg(consec_alert_reg),
    .rd_data(rd_data), .reg_pointer(reg_pointer), .wr_data(wr_data),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .hs_mode(hs_mode), .busy(busy));
  smbsp_master_model i_master (.mclk(mclk), .sda(sda), .scl_low(scl_low), .sda_low(sda_low));
  function automatic logic [7:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[7:0];
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (fail_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    if (rd_strobe === 1'b1) begin
      n_rd++;
    end
    if (wr_strobe === 1'b1) begin
      check("wr_data", wr_data, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
    end
  end
  initial begin
    #400_000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    logic       a;
    logic [7:0] p, d, r;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    check("ptr_reset", reg_pointer, 8'h00);
    p = rnd();
    i_master.start();
    i_master.wbyte({ADDR, 1'b0}, a);
    check("ack_addr", {7'h00, a}, 8'h01);
    i_master.wbyte(p, a);
    check("ack_ptr", {7'h00, a}, 8'h01);
    repeat (2) begin
      d = rnd();
      exp_q.push_back(d);
      i_master.wbyte(d, a);
      check("ack_data", {7'h00, a}, 8'h01);
    end
    i_master.stop();
    check("pointer", reg_pointer, p);
    // pointer-only write, restart, two-byte read
    p = rnd();
    i_master.start();
    i_master.wbyte({ADDR, 1'b0}, a);
    i_master.wbyte(p, a);
    i_master.start();
    i_master.wbyte({ADDR, 1'b1}, a);
    check("ack_rd", {7'h00, a}, 8'h01);
    i_master.rbyte(1'b1, r);
    check("rd0", r, p ^ 8'h3C);
    i_master.rbyte(1'b0, r);
    check("rd1", r, p ^ 8'h3C);
    i_master.stop();
    i_master.start();
    i_master.wbyte({ADDR, 1'b1}, a);
    i_master.rbyte(1'b0, r);
    i_master.stop();
    check("rd_again", r, p ^ 8'h3C);
    // foreign address is ignored
    i_master.start();
    i_master.wbyte({7'h4D, 1'b0}, a);
    check("ack_other", {7'h00, a}, 8'h00);
    i_master.wbyte(8'h00, a);
    check("ack_ignored", {7'h00, a}, 8'h00);
    i_master.stop();
    check("ptr_kept", reg_pointer, p);
    // high-speed entry held over a restart
    i_master.start();
    d = 8'h08 | (rnd() & 8'h07);
    i_master.wbyte(d, a);
    check("ack_code", {7'h00, a}, 8'h00);
    check("hs_on", {7'h00, hs_mode}, 8'h01);
    i_master.start();
    i_master.wbyte({ADDR, 1'b1}, a);
    i_master.rbyte(1'b0, r);
    check("rd_hs", r, p ^ 8'h3C);
    check("hs_kept", {7'h00, hs_mode}, 8'h01);
    i_master.stop();
    repeat (20) @(posedge mclk);
    check("hs_off", {7'h00, hs_mode}, 8'h00);
    // stuck-low bus with timeout off, then on
    i_master.start();
    repeat (TO + 200) @(posedge mclk);
    check("busy_no_to", {7'h00, busy}, 8'h01);
    i_master.stop();
    @(posedge mclk);
    consec_alert_reg <= 8'h81;
    i_master.start();
    i_master.wbyte({ADDR, 1'b0}, a);
    repeat (TO + 200) @(posedge mclk);
    check("busy_to", {7'h00, busy}, 8'h00);
    check("sda_free", {7'h00, sda_oe}, 8'h00);
    i_master.stop();
    check("rd_count", 8'(n_rd), 8'h04);
    check("wr_left", 8'(exp_q.size()), 8'h00);
    check("pins_low", {6'h00, scl_out, sda_out}, 8'h00);
    report_and_stop();
  end
endmodule // test_smbus_slave_pointer_interface

// >>> hw/smbsp_pkg.sv
// Purpose: shared constants for the two-wire slave pointer interface
// Assumes: system clock of 200 MHz
// Notes:   timing counts derive from printed times and the clock rate
package smbsp_pkg;
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned TIMEOUT_MS      = 25;
  localparam int unsigned TIMEOUT_CYCLES  = (CLK_HZ / 1000) * TIMEOUT_MS;
  localparam int unsigned FM_SCL_MAX_HZ   = 400_000;
  localparam int unsigned HS_SCL_MAX_HZ   = 2_500_000;
  localparam int unsigned SCL_MIN_HZ      = 1_000;
  // input glitch filter depth in ns and in clock cycles, fast and high-speed
  localparam int unsigned FM_FILT_NS      = 50;
  localparam int unsigned HS_FILT_NS      = 10;
  localparam int unsigned FM_FILT_CYCLES  = FM_FILT_NS / 5;
  localparam int unsigned HS_FILT_CYCLES  = HS_FILT_NS / 5;
  localparam logic [6:0]  ADDR_VARIANT_A  = 7'h49;
  localparam logic [6:0]  ADDR_VARIANT_B  = 7'h4C;
  localparam logic [6:0]  ADDR_VARIANT_C  = 7'h4E;
  localparam logic [4:0]  HS_CODE_TOP     = 5'h01;
  localparam logic [7:0]  POINTER_RESET   = 8'h00;
  localparam int unsigned TO_ENABLE_BIT   = 7;
  localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;
endpackage

// >>> hw/smbsp_slave.sv
// Purpose: two-wire / SMBus slave with register pointer, timeout and hs-mode entry
// Assumes: scl and sda sampled by mclk; register file lives outside this block
// Notes:   open-drain drive: oe high means pin pulled low
//
// Function
// RQ1 - slave only; open-drain sda and scl, never drives clock or conditions
// RQ2 - supports fast mode to 400 kHz and high-speed mode to 2.5 MHz
// RQ3 - every byte shifted most significant bit first
// RQ4 - start is sda falling while scl high, detected at any time
// RQ5 - address byte is seven address bits then direction, high reads
// RQ6 - on address match pull sda low in ninth clock pulse
// RQ7 - eight data clocks then acknowledge; sda change while scl high is control
// RQ8 - stop is sda rising while scl high; transfer ends with stop or restart
// RQ9 - both lines high means idle, no transfer in progress
// RQ10 - unlimited bytes per transfer; receiver acknowledges every byte
// RQ11 - acknowledge low held stable over the whole acknowledge high phase
// RQ12 - master ends reads with not-acknowledge on last byte
// RQ13 - first byte after write address loads the register pointer
// RQ14 - reads return register selected by last written pointer value
// RQ15 - pointer-only write accepted, then repeated start read allowed
// RQ16 - one fixed seven-bit address, variant 49, 4C or 4E hex
// RQ17 - timeout: line low 25 ms in transfer resets interface, releases lines
// RQ18 - timeout enabled by bit 7 of consecutive-alert register, default off
// RQ19 - master keeps scl at or above 1 kHz during a transfer
// RQ20 - master sends hs master code first after start to exceed 1 MHz
// RQ21 - master code 0000 1xxx is not acknowledged but enters hs filters
// RQ22 - hs mode held over restarts until stop, then back to fast
// RQ23 - pointer resets to zero at power-on
// RQ24 - address mismatch releases sda and ignores bus until next start
// RQ25 - read bits driven after scl falls; sda released in master ack slot
`timescale 1ns/1ps
module smbsp_slave #(
  parameter logic [6:0]  SLAVE_ADDR     = smbsp_pkg::ADDR_VARIANT_B,
  parameter int unsigned TIMEOUT_CYCLES = smbsp_pkg::TIMEOUT_CYCLES
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // two-wire pins
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // register file side
  input  wire logic [7:0] consec_alert_reg,
  input  wire logic [7:0] rd_data,
  output logic [7:0]      reg_pointer,
  output logic [7:0]      wr_data,
  output logic            wr_strobe,
  output logic            rd_strobe,
  // status
  output logic            hs_mode,
  output logic            busy
);

  typedef enum logic [5:0] {
    SMBSP_IDLE  = 6'b000001,
    SMBSP_ADDR  = 6'b000010,
    SMBSP_WRITE = 6'b000100,
    SMBSP_READ  = 6'b001000,
    SMBSP_MACK  = 6'b010000,
    SMBSP_IGN   = 6'b100000
  } smbsp_state_t;

  // synchronisers: first stage read only by the second
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
    end
  end

  // RQ2 RQ21 filter depth per mode
  logic [3:0] filt_len;
  logic [3:0] scl_cnt;
  logic [3:0] sda_cnt;
  logic       scl_f;
  logic       sda_f;
  logic       scl_q;
  logic       sda_q;
  always_comb begin
    filt_len = hs_mode ? 4'(smbsp_pkg::HS_FILT_CYCLES) : 4'(smbsp_pkg::FM_FILT_CYCLES);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scl_f   <= 1'b1;
      sda_f   <= 1'b1;
      scl_cnt <= 4'h0;
      sda_cnt <= 4'h0;
    end else begin
      if (scl_sync[1] == scl_f) begin
        scl_cnt <= 4'h0;
      end else if (scl_cnt >= filt_len) begin
        scl_f   <= scl_sync[1];
        scl_cnt <= 4'h0;
      end else begin
        scl_cnt <= scl_cnt + 4'h1;
      end
      if (sda_sync[1] == sda_f) begin
        sda_cnt <= 4'h0;
      end else if (sda_cnt >= filt_len) begin
        sda_f   <= sda_sync[1];
        sda_cnt <= 4'h0;
      end else begin
        sda_cnt <= sda_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise  = scl_f & ~scl_q;
  assign scl_fall  = ~scl_f & scl_q;
  // RQ4 start detection
  assign start_det = scl_f & scl_q & sda_q & ~sda_f;
  // RQ8 stop detection
  assign stop_det  = scl_f & scl_q & ~sda_q & sda_f;

  smbsp_state_t state;
  logic [3:0]   bit_cnt;
  logic [7:0]   shift;
  logic         ack_slot;
  logic         first_wr;
  logic         timeout_hit;
  logic [7:0]   tx_byte;

  // RQ17 bus-low timer
  logic [$clog2(TIMEOUT_CYCLES+1)-1:0] to_cnt;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      to_cnt      <= '0;
      timeout_hit <= 1'b0;
    end else begin
      timeout_hit <= 1'b0;
      // RQ18 enable bit gates the timer
      if (!consec_alert_reg[smbsp_pkg::TO_ENABLE_BIT] || state == SMBSP_IDLE
          || (scl_f && sda_f)) begin
        to_cnt <= '0;
      end else if (to_cnt >= ($bits(to_cnt))'(TIMEOUT_CYCLES - 1)) begin
        to_cnt      <= '0;
        timeout_hit <= 1'b1;
      end else begin
        to_cnt <= to_cnt + 1'b1;
      end
    end
  end

  // main byte engine; RQ9 idle when no transfer
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state     <= SMBSP_IDLE;
      bit_cnt   <= 4'h0;
      shift     <= 8'h00;
      ack_slot  <= 1'b0;
      first_wr  <= 1'b0;
      wr_data   <= 8'h00;
      wr_strobe <= 1'b0;
      rd_strobe <= 1'b0;
      tx_byte   <= 8'h00;
      // RQ23 pointer power-on value
      reg_pointer <= smbsp_pkg::POINTER_RESET;
    end else begin
      wr_strobe <= 1'b0;
      rd_strobe <= 1'b0;
      if (timeout_hit || stop_det) begin
        state    <= SMBSP_IDLE;
        ack_slot <= 1'b0;
      end else if (start_det) begin
        // RQ24 any start or restart leaves the ignore state
        state    <= SMBSP_ADDR;
        bit_cnt  <= 4'h0;
        ack_slot <= 1'b0;
      end else if (scl_rise && !ack_slot) begin
        // RQ3 RQ7 msb first on scl rise
        shift   <= {shift[6:0], sda_f};
        bit_cnt <= bit_cnt + 4'h1;
        if (state == SMBSP_READ) begin
          shift <= {shift[6:0], 1'b0};
        end
      end else if (scl_rise && ack_slot && state == SMBSP_MACK) begin
        // RQ12 master nack ends read
        if (sda_f) begin
          state <= SMBSP_IGN;
        end else begin
          state     <= SMBSP_READ;
          tx_byte   <= rd_data;
          rd_strobe <= 1'b1;
        end
      end else if (scl_fall && ack_slot) begin
        ack_slot <= 1'b0;
        bit_cnt  <= 4'h0;
        if (state == SMBSP_READ) begin
          shift <= tx_byte;
        end
      end else if (scl_fall && bit_cnt == smbsp_pkg::BITS_PER_BYTE) begin
        ack_slot <= 1'b1;
        case (state)
          SMBSP_ADDR: begin
            // RQ16 RQ5 address compare and direction
            if (shift[7:1] == SLAVE_ADDR) begin
              state    <= shift[0] ? SMBSP_READ : SMBSP_WRITE;
              first_wr <= ~shift[0];
              tx_byte  <= rd_data;
              if (shift[0]) begin
                rd_strobe <= 1'b1;
              end
            end else begin
              state <= SMBSP_IGN;
            end
          end
          SMBSP_WRITE: begin
            // RQ13 RQ15 first write byte loads pointer
            if (first_wr) begin
              reg_pointer <= shift;
              first_wr    <= 1'b0;
            end else begin
              wr_data   <= shift;
              wr_strobe <= 1'b1;
            end
          end
          SMBSP_READ: begin
            // RQ25 release in master ack slot
            state <= SMBSP_MACK;
          end
          default: begin
            state <= SMBSP_IGN;
          end
        endcase
      end
    end
  end

  // RQ21 RQ22 hs master code enters hs mode until stop or timeout
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hs_mode <= 1'b0;
    end else if (stop_det || timeout_hit) begin
      hs_mode <= 1'b0;
    end else if (scl_fall && !ack_slot && state == SMBSP_ADDR
                 && bit_cnt == smbsp_pkg::BITS_PER_BYTE
                 && shift[7:3] == smbsp_pkg::HS_CODE_TOP) begin
      hs_mode <= 1'b1;
    end
  end

  // sda drive: RQ6 RQ10 RQ11 ack low across the ack pulse, RQ14 RQ25 read data
  logic next_sda_oe;
  always_comb begin
    next_sda_oe = sda_oe;
    if (timeout_hit || stop_det || start_det) begin
      next_sda_oe = 1'b0;
    end else if (scl_fall) begin
      if (!ack_slot && bit_cnt == smbsp_pkg::BITS_PER_BYTE) begin
        next_sda_oe = (state == SMBSP_ADDR && shift[7:1] == SLAVE_ADDR)
                      || state == SMBSP_WRITE;
      end else if (ack_slot) begin
        next_sda_oe = (state == SMBSP_READ) ? ~tx_byte[7] : 1'b0;
      end else if (state == SMBSP_READ) begin
        next_sda_oe = ~shift[7];
      end else begin
        next_sda_oe = 1'b0;
      end
    end else if (scl_rise && ack_slot && state == SMBSP_MACK && !sda_f) begin
      next_sda_oe = 1'b0;
    end
  end

  // RQ1 open drain only; scl never driven
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sda_oe  <= 1'b0;
      sda_out <= 1'b0;
      scl_oe  <= 1'b0;
      scl_out <= 1'b0;
      busy    <= 1'b0;
    end else begin
      sda_oe  <= next_sda_oe;
      sda_out <= 1'b0;
      scl_oe  <= 1'b0;
      scl_out <= 1'b0;
      busy    <= (state != SMBSP_IDLE);
    end
  end

  // RQ1 never drives clock
  a_scl_never_driven: assert property (@(posedge mclk) disable iff (rst) // RQ1
    !scl_oe)
    else $error("scl driven by slave");

  // RQ17 after timeout sda released
  a_timeout_release: assert property (@(posedge mclk) disable iff (rst) // RQ17
    timeout_hit |-> ##2 !sda_oe)
    else $error("sda held after timeout");

  // RQ22 stop clears hs mode
  a_hs_stop_clear: assert property (@(posedge mclk) disable iff (rst) // RQ22
    stop_det |=> !hs_mode)
    else $error("hs mode kept after stop");

  // RQ4 start moves to address
  a_start_addr: assert property (@(posedge mclk) disable iff (rst) // RQ4
    (start_det && !stop_det && !timeout_hit) |=> state == SMBSP_ADDR)
    else $error("start not taken");

  // RQ8 stop goes idle
  a_stop_idle: assert property (@(posedge mclk) disable iff (rst) // RQ8
    stop_det |=> state == SMBSP_IDLE)
    else $error("stop not taken");

  // RQ24 ignore state never drives sda
  a_ign_release: assert property (@(posedge mclk) disable iff (rst) // RQ24
    (state == SMBSP_IGN && $past(state) == SMBSP_IGN) |=> !sda_oe)
    else $error("sda driven while ignoring");

  // RQ14 pointer changes only in write state
  a_ptr_write: assert property (@(posedge mclk) disable iff (rst) // RQ14
    (reg_pointer != $past(reg_pointer)) |-> $past(state) == SMBSP_WRITE)
    else $error("pointer changed outside write");

  // RQ11 ack held while scl high
  a_ack_stable: assert property (@(posedge mclk) disable iff (rst) // RQ11
    (ack_slot && state == SMBSP_WRITE && sda_oe && scl_f && !stop_det
     && !start_det && !timeout_hit) |=> sda_oe)
    else $error("ack released during high phase");

endmodule // smbsp_slave
